/* rtl/sae_mmu.sv */
// Segment address extension unit: segment registers and address forming
`timescale 1ns/10ps
module sae_mmu (
   input  wire logic mclk,
   input  wire logic rst_b,
   sae_if.mmu        link
);
   // All state of the unit
   typedef struct packed {
      logic [5:0]      cs;        // code_segment
      logic [5:0]      iseg;      // interrupt_segment
      logic [5:0]      dseg;      // dma_segment
      logic [3:0][7:0] page;      // data_page_register 0-3
      logic [3:0][7:0] port;      // Port 0-3 data registers
      logic            remap;     // page_register_remap
      logic            saveCs;    // save_code_segment_mode
      logic [3:0]      depth;     // Open interrupt levels
      logic [7:0]      frames;    // Per level: frame carried code_segment
      logic            rspValid;  // Answer strobe
      logic [21:0]     rspAddr;   // Answer address
      logic [7:0]      rspData;   // Answer byte
      logic            rspCsPush; // Answer: code_segment in frame
      logic            isrFetch;  // Fetch source flag
   } sae_mmu_t;

   // State copies: one registered, one worked out each cycle
   sae_mmu_t s_q;    // Registered state
   sae_mmu_t s_d;    // Next state
   // Decode helpers for the current request
   logic     pageHit; // Address selects a data page register
   logic     portHit; // Address selects a port data register
   logic [1:0] idx;  // Register index within a group of four
   logic [5:0] fseg; // Segment used for instruction fetch

   // Register map decode; the two groups trade places when remapped
   always_comb begin
      // Low two address bits pick one register of a group of four
      idx = link.reqAddr[1:0];
      // Compare address bits 7:2, above the index bits, against each group base
      if (s_q.remap) begin
         pageHit = link.reqAddr[7:2] == sae_pkg::PORT_BASE[7:2];
         portHit = link.reqAddr[7:2] == sae_pkg::PAGE_BASE[7:2];
      end else begin
         pageHit = link.reqAddr[7:2] == sae_pkg::PAGE_BASE[7:2];
         portHit = link.reqAddr[7:2] == sae_pkg::PORT_BASE[7:2];
      end
   end

   // Fetch source: the interrupt segment while the newest open level
   // is a default-mode entry, the code segment otherwise
   // A save-mode level has loaded code_segment already, so it wins
   always_comb begin
      if (s_q.depth != 4'h0 && !s_q.frames[0]) begin
         fseg = s_q.iseg;
      end else begin
         fseg = s_q.cs;
      end
   end

   // Request handling: every request is answered at the next edge;
   // answer fields other than the strobe hold until the next answer
   always_comb begin
      s_d = s_q;
      s_d.rspValid = 1'b0;
      if (link.reqValid) begin
         s_d.rspValid  = 1'b1;
         // Zero address for requests that form none
         s_d.rspAddr   = '0;
         s_d.rspData   = sae_pkg::BYTE_RST;
         s_d.rspCsPush = 1'b0;
         unique case (link.reqOp)
            // Register write; segment registers keep only six bits
            sae_pkg::OP_REG_WR: begin
               // Page and port registers keep all eight bits
               if (pageHit) begin
                  s_d.page[idx] = link.reqData;
               end else if (portHit) begin
                  s_d.port[idx] = link.reqData;
               end else if (link.reqAddr[7:0] == sae_pkg::CODE_OFS) begin
                  s_d.cs = link.reqData[5:0];
               end else if (link.reqAddr[7:0] == sae_pkg::MODE2_OFS) begin
                  s_d.remap  = link.reqData[sae_pkg::REMAP_BIT];
                  s_d.saveCs = link.reqData[sae_pkg::SAVECS_BIT];
               end else if (link.reqAddr[7:0] == sae_pkg::ISEG_OFS) begin
                  s_d.iseg = link.reqData[5:0];
               end else if (link.reqAddr[7:0] == sae_pkg::DSEG_OFS) begin
                  s_d.dseg = link.reqData[5:0];
               end
            end
            // Register read; unimplemented bits and locations read zero
            sae_pkg::OP_REG_RD: begin
               // Group decode already allows for the remap swap
               if (pageHit) begin
                  s_d.rspData = s_q.page[idx];
               end else if (portHit) begin
                  s_d.rspData = s_q.port[idx];
               end else if (link.reqAddr[7:0] == sae_pkg::CODE_OFS) begin
                  s_d.rspData = {2'b00, s_q.cs};
               end else if (link.reqAddr[7:0] == sae_pkg::MODE2_OFS) begin
                  s_d.rspData = {1'b0, s_q.saveCs, s_q.remap, 5'b0_0000};
               end else if (link.reqAddr[7:0] == sae_pkg::ISEG_OFS) begin
                  s_d.rspData = {2'b00, s_q.iseg};
               end else if (link.reqAddr[7:0] == sae_pkg::DSEG_OFS) begin
                  s_d.rspData = {2'b00, s_q.dseg};
               end
            end
            // Instruction fetch
            sae_pkg::OP_FETCH: begin
               // Segment on bits 21:16, virtual address below
               s_d.rspAddr = {fseg, link.reqAddr};
            end
            // Data access: never looks at the save mode
            sae_pkg::OP_DATA: begin
               // Top two virtual bits pick the page register
               s_d.rspAddr = {s_q.page[link.reqAddr[15:14]],
                              link.reqAddr[13:0]};
            end
            // Peripheral-memory DMA
            sae_pkg::OP_DMA: begin
               // Never code_segment: a DMA finds its segment whatever the program jumped to
               if (link.reqSel) begin
                  s_d.rspAddr = {s_q.dseg, link.reqAddr};
               end else begin
                  s_d.rspAddr = {s_q.iseg, link.reqAddr};
               end
            end
            // Interrupt entry: vector lies in the interrupt segment
            sae_pkg::OP_INT_ENT: begin
               s_d.rspAddr = {s_q.iseg, link.reqAddr};
               // Per level, note whether the frame carries code_segment
               s_d.frames  = {s_q.frames[6:0], s_q.saveCs};
               // Deeper nesting than tracked loses the oldest level
               if (s_q.depth != 4'(sae_pkg::NEST_N)) begin
                  s_d.depth = s_q.depth + 4'h1;
               end
               // Save mode: old code_segment goes out for the stack frame
               if (s_q.saveCs) begin
                  s_d.rspCsPush = 1'b1;
                  s_d.rspData   = {2'b00, s_q.cs};
                  s_d.cs        = s_q.iseg;
               end
            end
            // Interrupt return: pops the newest level
            sae_pkg::OP_INT_RET: begin
               if (s_q.depth != 4'h0) begin
                  s_d.depth  = s_q.depth - 4'h1;
                  s_d.frames = {1'b0, s_q.frames[7:1]};
                  // Only a save-mode frame holds a code_segment to restore
                  if (s_q.frames[0]) begin
                     s_d.cs = link.reqData[5:0];
                  end
               end else if (s_q.saveCs) begin
                  // No level on record: follow the mode as it is now
                  s_d.cs = link.reqData[5:0];
               end
               s_d.rspCsPush = s_q.depth != 4'h0 ? s_q.frames[0] : s_q.saveCs;
            end
            // Far jump, call or return: loads the code segment only, so
            // inside a default-mode routine fetch stays on interrupt_segment
            sae_pkg::OP_FAR: begin
               // Call, jump and return differ only on the stack, not here
               s_d.cs = link.reqData[5:0];
            end
         endcase
      end
      // Flag mirrors the fetch source as it stands after this edge
      s_d.isrFetch = s_d.depth != 4'h0 && !s_d.frames[0];
   end

   // State register; code segment clears, others to known zero
   // Segment and page registers have no defined reset in hardware; zero keeps runs repeatable
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '0;
         s_q.cs <= sae_pkg::CODE_RST;
         s_q.iseg <= sae_pkg::SEG_RST;
         s_q.dseg <= sae_pkg::SEG_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from the state flops,
   // so the link never sees a combinational glitch
   assign link.rspValid  = s_q.rspValid;
   assign link.rspAddr   = s_q.rspAddr;
   assign link.rspData   = s_q.rspData;
   assign link.rspCsPush = s_q.rspCsPush;
   assign link.isrFetch  = s_q.isrFetch;
endmodule : sae_mmu

/* rtl/sae_pkg.sv */
// Shared constants and types for the segment address extension
package sae_pkg;
   // Register file locations inside the segment/page group
   localparam logic [7:0] PORT_BASE  = 8'hE0; // Port 0-3 data, normal place
   localparam logic [7:0] PAGE_BASE  = 8'hF0; // Data page 0-3, normal place
   localparam logic [7:0] CODE_OFS   = 8'hF4; // code_segment
   localparam logic [7:0] MODE2_OFS  = 8'hF6; // extended_mode_register_two
   localparam logic [7:0] ISEG_OFS   = 8'hF8; // interrupt_segment
   localparam logic [7:0] DSEG_OFS   = 8'hF9; // dma_segment
   // Field positions in extended_mode_register_two
   localparam int REMAP_BIT  = 5; // page_register_remap
   localparam int SAVECS_BIT = 6; // save_code_segment_mode
   // Widths
   localparam int SEG_W  = 6;  // Implemented segment bits
   localparam int VA_W   = 16; // Virtual address
   localparam int PA_W   = 22; // Physical address
   localparam int OFS_W  = 14; // Page offset
   localparam int NEST_N = 8;  // Tracked interrupt nesting levels
   // Reset values
   localparam logic [5:0] CODE_RST = 6'h00;
   localparam logic [5:0] SEG_RST  = 6'h00;
   localparam logic [7:0] BYTE_RST = 8'h00;
   // Controller APB register byte offsets
   localparam logic [7:0] C_CMD    = 8'h00; // [2:0] op, [8] dma_segment_select
   localparam logic [7:0] C_ADDR   = 8'h04; // [15:0] virtual or register address
   localparam logic [7:0] C_WDATA  = 8'h08; // [7:0] operand
   localparam logic [7:0] C_STAT   = 8'h0C; // [0] busy [1] cs pushed [2] routine fetch [3] refused
   localparam logic [7:0] C_RES    = 8'h10; // [21:0] physical address
   localparam logic [7:0] C_RDATA  = 8'h14; // [7:0] returned byte
   localparam int CMD_SEL_BIT = 8;
   // Requests from the core/DMA side
   typedef enum logic [2:0] {
      OP_REG_WR  = 3'b000,
      OP_REG_RD  = 3'b001,
      OP_FETCH   = 3'b010,
      OP_DATA    = 3'b011,
      OP_DMA     = 3'b100,
      OP_INT_ENT = 3'b101,
      OP_INT_RET = 3'b110,
      OP_FAR     = 3'b111
   } sae_op_t;
endpackage : sae_pkg

/* rtl/sae_if.sv */
// Link between the core/DMA controller and the segment unit
`timescale 1ns/10ps
interface sae_if;
   logic            reqValid;  // One-cycle request strobe
   sae_pkg::sae_op_t reqOp;    // Request kind
   logic [15:0]     reqAddr;   // Virtual or register address
   logic [7:0]      reqData;   // Write byte, segment or popped code segment
   logic            reqSel;    // dma_segment_select for DMA requests
   logic            rspValid;  // One-cycle answer strobe
   logic [21:0]     rspAddr;   // Physical address
   logic [7:0]      rspData;   // Read byte or code segment to push
   logic            rspCsPush; // Interrupt frame holds the code segment
   logic            isrFetch;  // Fetch segment is interrupt_segment (level)
   modport mmu (input reqValid, reqOp, reqAddr, reqData, reqSel,
                output rspValid, rspAddr, rspData, rspCsPush, isrFetch);
   modport core (output reqValid, reqOp, reqAddr, reqData, reqSel,
                 input rspValid, rspAddr, rspData, rspCsPush, isrFetch);
endinterface : sae_if

/* rtl/sae_ctl.sv */
// Core/DMA side controller: APB command registers driving the link
`timescale 1ns/10ps
module sae_ctl (
   input  wire logic        mclk,
   input  wire logic        rst_b,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   sae_if.core              link
);
   // All state of the controller
   typedef struct packed {
      logic             pready;  // Access-phase answer
      logic [31:0]      prdata;  // Read data
      logic             pslverr; // Unmapped offset
      logic [15:0]      addr;    // Address operand
      logic [7:0]       wdata;   // Byte operand
      logic             busy;    // Request waiting for answer
      logic             csPush;  // Last frame carried code segment
      logic             refused; // Last command dropped
      logic [21:0]      res;     // Last physical address
      logic [7:0]       rdata;   // Last returned byte
      logic             reqValid;
      sae_pkg::sae_op_t reqOp;
      logic             reqSel;
   } sae_ctl_t;

   sae_ctl_t s_q;   // Registered state
   sae_ctl_t s_d;   // Next state
   logic     setup; // APB setup cycle seen
   logic     csWr;  // Command writes code_segment
   logic     segWr; // Command writes interrupt_segment or dma_segment
   sae_pkg::sae_op_t op; // Command opcode

   always_comb begin
      setup = psel && !penable;
      op    = sae_pkg::sae_op_t'(pwdata[2:0]);
      csWr  = op == sae_pkg::OP_REG_WR && s_q.addr[7:0] == sae_pkg::CODE_OFS;
      segWr = op == sae_pkg::OP_REG_WR &&
              (s_q.addr[7:0] == sae_pkg::ISEG_OFS ||
               s_q.addr[7:0] == sae_pkg::DSEG_OFS);
   end

   // APB slave plus link sequencing; every access answers without a wait cycle
   always_comb begin
      s_d = s_q;
      s_d.pready   = setup;
      s_d.reqValid = 1'b0;
      s_d.pslverr  = 1'b0;
      if (setup) begin
         s_d.prdata  = '0;
         s_d.pslverr = paddr > sae_pkg::C_RDATA || paddr[1:0] != 2'b00;
         if (pwrite) begin
            if (paddr == sae_pkg::C_ADDR) begin
               s_d.addr = pwdata[15:0];
            end else if (paddr == sae_pkg::C_WDATA) begin
               s_d.wdata = pwdata[7:0];
            end else if (paddr == sae_pkg::C_CMD) begin
               // Busy, or a code segment write while it is in use, is dropped
               if (s_q.busy || (csWr && !link.isrFetch)) begin
                  s_d.refused = 1'b1;
               end else begin
                  s_d.refused  = 1'b0;
                  s_d.reqValid = 1'b1;
                  s_d.busy     = 1'b1;
                  s_d.reqOp    = op;
                  s_d.reqSel   = pwdata[sae_pkg::CMD_SEL_BIT];
                  // Reserved bits sent as zero for interrupt_segment and dma_segment writes
                  if (segWr) begin
                     s_d.wdata = {2'b00, s_q.wdata[5:0]};
                  end
               end
            end
         end else begin
            unique case (paddr)
               sae_pkg::C_ADDR:  s_d.prdata = {16'h0000, s_q.addr};
               sae_pkg::C_WDATA: s_d.prdata = {24'h00_0000, s_q.wdata};
               sae_pkg::C_STAT:  s_d.prdata = {28'h000_0000, s_q.refused,
                                               link.isrFetch, s_q.csPush, s_q.busy};
               sae_pkg::C_RES:   s_d.prdata = {10'h000, s_q.res};
               sae_pkg::C_RDATA: s_d.prdata = {24'h00_0000, s_q.rdata};
               default:          s_d.prdata = '0;
            endcase
         end
      end
      // Answer from the segment unit closes the request
      if (link.rspValid) begin
         s_d.busy   = 1'b0;
         s_d.res    = link.rspAddr;
         s_d.rdata  = link.rspData;
         s_d.csPush = link.rspCsPush;
      end
   end

   // State register
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs from flops
   assign pready       = s_q.pready;
   assign prdata       = s_q.prdata;
   assign pslverr      = s_q.pslverr;
   assign link.reqValid = s_q.reqValid;
   assign link.reqOp    = s_q.reqOp;
   assign link.reqAddr  = s_q.addr;
   assign link.reqData  = s_q.wdata;
   assign link.reqSel   = s_q.reqSel;
endmodule : sae_ctl

/* testbench/sae_checker.sv */
// Link checker: timing and address forming seen between controller and segment unit
`timescale 1ns/10ps
module sae_checker (
   input wire logic             mclk,
   input wire logic             rst_b,
   input wire logic             reqValid,
   input wire sae_pkg::sae_op_t reqOp,
   input wire logic [15:0]      reqAddr,
   input wire logic [7:0]       reqData,
   input wire logic             reqSel,
   input wire logic             rspValid,
   input wire logic [21:0]      rspAddr,
   input wire logic [7:0]       rspData,
   input wire logic             rspCsPush,
   input wire logic             isrFetch
);
   logic [5:0] isegQ;  // Shadow interrupt_segment
   logic [5:0] dsegQ;  // Shadow dma_segment
   logic       saveQ;  // Shadow save_code_segment_mode
   wire        wrReg = reqValid && reqOp == sae_pkg::OP_REG_WR;
   wire        entry = reqValid && reqOp == sae_pkg::OP_INT_ENT;
   wire        dma   = reqValid && reqOp == sae_pkg::OP_DMA;

   // Shadows follow observed register writes, so no body knowledge is needed
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         isegQ <= 6'h00;
         dsegQ <= 6'h00;
         saveQ <= 1'b0;
      end else if (wrReg) begin
         if (reqAddr[7:0] == sae_pkg::ISEG_OFS) isegQ <= reqData[5:0];
         if (reqAddr[7:0] == sae_pkg::DSEG_OFS) dsegQ <= reqData[5:0];
         if (reqAddr[7:0] == sae_pkg::MODE2_OFS) saveQ <= reqData[sae_pkg::SAVECS_BIT];
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   chk_answer_next: assert property (reqValid |=> rspValid)
      else $error("no answer one cycle after request");
   chk_answer_cause: assert property (rspValid |-> $past(reqValid))
      else $error("answer without request");
   chk_int_vector: assert property (entry |=> rspAddr == {isegQ, $past(reqAddr)})
      else $error("interrupt entry address wrong");
   chk_dma_sel_one: assert property (dma && reqSel |=> rspAddr == {dsegQ, $past(reqAddr)})
      else $error("dma address with select one wrong");
   chk_dma_sel_zero: assert property (dma && !reqSel |=> rspAddr == {isegQ, $past(reqAddr)})
      else $error("dma address with select zero wrong");
   chk_default_entry: assert property (entry && !saveQ |=> isrFetch && !rspCsPush)
      else $error("default entry frame or fetch source wrong");
   chk_save_entry: assert property (entry && saveQ |=> rspCsPush && !isrFetch)
      else $error("save mode entry did not push code segment");
   chk_isr_fetch: assert property (reqValid && reqOp == sae_pkg::OP_FETCH && isrFetch
                                   |=> rspAddr == {isegQ, $past(reqAddr)})
      else $error("fetch in routine not via interrupt segment");
   chk_source_hold: assert property ($changed(isrFetch) |-> rspValid)
      else $error("fetch source changed without answer");

   cover property (entry && saveQ);
   cover property (dma && reqSel);
   cover property (reqValid && reqOp == sae_pkg::OP_INT_RET && isrFetch);
endmodule : sae_checker

/* testbench/tb_segment_address_extension.sv */
// Bench: controller drives the segment unit over the link, checked through APB
`timescale 1ns/10ps
module tb_segment_address_extension;
   logic        mclk    = 1'b0;
   logic        rst_b   = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h0000_0000;
   logic [31:0] prdata, rd, res, rdat, stat;  // Bus data and command results
   logic        pready, pslverr, err;
   int          bad_count   = 0;
   int          check_count = 0;

   sae_if link ();
   sae_mmu i_sae_mmu (.mclk(mclk), .rst_b(rst_b), .link(link));
   sae_ctl i_sae_ctl (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
                      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
                      .link(link));
   sae_checker i_sae_checker (.mclk(mclk), .rst_b(rst_b), .reqValid(link.reqValid), .reqOp(link.reqOp),
                              .reqAddr(link.reqAddr), .reqData(link.reqData), .reqSel(link.reqSel),
                              .rspValid(link.rspValid), .rspAddr(link.rspAddr), .rspData(link.rspData),
                              .rspCsPush(link.rspCsPush), .isrFetch(link.isrFetch));

   // 25 MHz clock
   always #20 mclk = ~mclk;

   // Compare and count; X never matches
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   // One APB transfer, entered just after a rising edge; holds until pready
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask : apb

   // One link command: load operands, start, wait for idle, collect results
   task automatic op(input sae_pkg::sae_op_t o, input logic s, input logic [15:0] a, input logic [7:0] d);
      apb(1'b1, sae_pkg::C_ADDR, {16'h0000, a});
      apb(1'b1, sae_pkg::C_WDATA, {24'h00_0000, d});
      apb(1'b1, sae_pkg::C_CMD, {23'h00_0000, s, 5'h00, o});
      do apb(1'b0, sae_pkg::C_STAT, 32'h0000_0000); while (rd[0] !== 1'b0);
      stat = rd;
      apb(1'b0, sae_pkg::C_RES, 32'h0000_0000);
      res = rd;
      apb(1'b0, sae_pkg::C_RDATA, 32'h0000_0000);
      rdat = rd;
   endtask : op

   // Reset state and plain fetch
   task automatic t_reset;
      op(sae_pkg::OP_REG_RD, 1'b0, {8'h00, sae_pkg::CODE_OFS}, 8'h00);
      check("code_segment", 32'h0000_0000, rdat);
      op(sae_pkg::OP_FETCH, 1'b0, 16'hBEEF, 8'h00);
      check("fetch address", 32'h0000_BEEF, res);
      $display("test reset done");
   endtask : t_reset

   // Segment registers, DMA source choice, unmapped APB offset
   task automatic t_segments;
      op(sae_pkg::OP_REG_WR, 1'b0, {8'h00, sae_pkg::ISEG_OFS}, 8'hFF);
      op(sae_pkg::OP_REG_RD, 1'b0, {8'h00, sae_pkg::ISEG_OFS}, 8'h00);
      check("interrupt_segment", 32'h0000_003F, rdat);
      op(sae_pkg::OP_REG_WR, 1'b0, {8'h00, sae_pkg::DSEG_OFS}, 8'h2A);
      op(sae_pkg::OP_DMA, 1'b1, 16'h1234, 8'h00);
      check("dma select one", 32'h002A_1234, res);
      op(sae_pkg::OP_DMA, 1'b0, 16'h1234, 8'h00);
      check("dma select zero", 32'h003F_1234, res);
      apb(1'b0, 8'h18, 32'h0000_0000);
      check("unmapped error", 32'h0000_0001, {31'h0000_0000, err});
      $display("test segments done");
   endtask : t_segments

   // Every page quadrant, then the remapped page location
   task automatic t_pages;
      for (int i = 0; i < 4; i++) begin
         op(sae_pkg::OP_REG_WR, 1'b0, {8'h00, sae_pkg::PAGE_BASE + 8'(i)}, 8'hA0 + 8'(i));
         op(sae_pkg::OP_DATA, 1'b0, {2'(i), 14'h0155}, 8'h00);
         check("data address", {10'h000, 8'hA0 + 8'(i), 14'h0155}, res);
      end
      op(sae_pkg::OP_REG_WR, 1'b0, {8'h00, sae_pkg::MODE2_OFS}, 8'h20);
      op(sae_pkg::OP_REG_WR, 1'b0, {8'h00, sae_pkg::PORT_BASE + 8'h01}, 8'h5C);
      op(sae_pkg::OP_DATA, 1'b0, 16'h4155, 8'h00);
      check("remapped page", 32'h0017_0155, res);
      op(sae_pkg::OP_REG_WR, 1'b0, {8'h00, sae_pkg::MODE2_OFS}, 8'h00);
      $display("test pages done");
   endtask : t_pages

   // Default interrupt mode: nesting, far ops, code_segment write window
   task automatic t_default_int;
      op(sae_pkg::OP_REG_WR, 1'b0, {8'h00, sae_pkg::CODE_OFS}, 8'h11);
      check("refused write", 32'h0000_0001, {31'h0000_0000, stat[3]});
      op(sae_pkg::OP_INT_ENT, 1'b0, 16'h0040, 8'h00);
      check("vector address", 32'h003F_0040, res);
      check("default frame", 32'h0000_0002, {30'h0000_0000, stat[2:1]});
      op(sae_pkg::OP_REG_WR, 1'b0, {8'h00, sae_pkg::CODE_OFS}, 8'h11);
      check("allowed write", 32'h0000_0000, {31'h0000_0000, stat[3]});
      op(sae_pkg::OP_INT_ENT, 1'b0, 16'h0044, 8'h00);
      op(sae_pkg::OP_INT_RET, 1'b0, 16'h0000, 8'h00);
      check("nested source", 32'h0000_0001, {31'h0000_0000, stat[2]});
      op(sae_pkg::OP_FAR, 1'b0, 16'h0000, 8'h05);
      op(sae_pkg::OP_FETCH, 1'b0, 16'h0200, 8'h00);
      check("routine fetch", 32'h003F_0200, res);
      op(sae_pkg::OP_INT_RET, 1'b0, 16'h0000, 8'h00);
      op(sae_pkg::OP_FETCH, 1'b0, 16'h0300, 8'h00);
      check("main fetch", 32'h0005_0300, res);
      $display("test default interrupt done");
   endtask : t_default_int

   // Save mode: code segment pushed, loaded, restored; data path unchanged
   task automatic t_save_int;
      logic [7:0] keep; // Page value saved by the routine
      op(sae_pkg::OP_REG_WR, 1'b0, {8'h00, sae_pkg::MODE2_OFS}, 8'h40);
      op(sae_pkg::OP_INT_ENT, 1'b0, 16'h0080, 8'h00);
      check("pushed segment", 32'h0000_0105, {23'h00_0000, stat[1], rdat[7:0]});
      op(sae_pkg::OP_FETCH, 1'b0, 16'h0010, 8'h00);
      check("loaded segment", 32'h003F_0010, res);
      op(sae_pkg::OP_FAR, 1'b0, 16'h0000, 8'h05);
      op(sae_pkg::OP_FETCH, 1'b0, 16'h0020, 8'h00);
      check("far call in routine", 32'h0005_0020, res);
      op(sae_pkg::OP_FAR, 1'b0, 16'h0000, 8'h3F);
      op(sae_pkg::OP_DATA, 1'b0, 16'h4155, 8'h00);
      check("data in routine", 32'h0017_0155, res);
      op(sae_pkg::OP_REG_RD, 1'b0, {8'h00, sae_pkg::PAGE_BASE + 8'h01}, 8'h00);
      keep = rdat[7:0];
      check("saved page", 32'h0000_005C, rdat);
      op(sae_pkg::OP_REG_WR, 1'b0, {8'h00, sae_pkg::PAGE_BASE + 8'h01}, 8'h33);
      op(sae_pkg::OP_DATA, 1'b0, 16'h4155, 8'h00);
      check("loaded page", 32'h000C_C155, res);
      op(sae_pkg::OP_REG_WR, 1'b0, {8'h00, sae_pkg::PAGE_BASE + 8'h01}, keep);
      op(sae_pkg::OP_INT_RET, 1'b0, 16'h0000, 8'h05);
      op(sae_pkg::OP_REG_RD, 1'b0, {8'h00, sae_pkg::CODE_OFS}, 8'h00);
      check("restored segment", 32'h0000_0005, rdat);
      op(sae_pkg::OP_DATA, 1'b0, 16'h4155, 8'h00);
      check("restored page", 32'h0017_0155, res);
      $display("test save interrupt done");
   endtask : t_save_int

   // Counts, verdict, end of run
   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : final_report

   // Main sequence after two reset cycles
   initial begin
      repeat (2) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
      t_reset();
      t_segments();
      t_pages();
      t_default_int();
      t_save_int();
      final_report();
   end

   // Watchdog: the sequence needs several hundred cycles
   initial begin
      repeat (40000) @(posedge mclk);
      bad_count++;
      final_report();
   end
endmodule : tb_segment_address_extension
